// file: core/codm_consts.vh
`ifndef CODM_CONSTS_VH
`define CODM_CONSTS_VH

// ----------------------------------------
// Opcode groups and patterns
// ----------------------------------------
`define CODM_GRP_LOW         2'h0
`define CODM_GRP_MOVE        2'h1
`define CODM_GRP_HIGH        2'h3
`define CODM_NIB_PAIR_LOAD   4'h1
`define CODM_NIB_POP         4'h1
`define CODM_NIB_PUSH        4'h5
`define CODM_OP_SWAP_DE_HL   8'heb
`define CODM_OP_SWAP_TOP_HL  8'he3
`define CODM_OP_HL_TO_SP     8'hf9
`define CODM_MEM_CODE        3'h6
`define CODM_PAIR_SPECIAL    2'h3

// ----------------------------------------
// Instruction classes
// ----------------------------------------
`define CODM_CLS_W           4
`define CODM_CLS_NONE        4'h0
`define CODM_CLS_COPY_REG    4'h1
`define CODM_CLS_STORE_MEM   4'h2
`define CODM_CLS_LOAD_MEM    4'h3
`define CODM_CLS_LOAD_PAIR   4'h4
`define CODM_CLS_SWAP_DE_HL  4'h5
`define CODM_CLS_PUSH        4'h6
`define CODM_CLS_POP         4'h7
`define CODM_CLS_SWAP_TOP    4'h8
`define CODM_CLS_HL_TO_SP    4'h9

// ----------------------------------------
// Clock cycle counts
// ----------------------------------------
`define CODM_CYC_W           5
`define CODM_CYC_NONE        5'h00
`define CODM_CYC_COPY        5'h04
`define CODM_CYC_MEM_MOVE    5'h07
`define CODM_CYC_LOAD_PAIR   5'h0a
`define CODM_CYC_SWAP_DE_HL  5'h04
`define CODM_CYC_PUSH        5'h0c
`define CODM_CYC_POP         5'h0a
`define CODM_CYC_SWAP_TOP    5'h10
`define CODM_CYC_HL_TO_SP    5'h06
`define CODM_CYC_ONE         5'h01

`endif

// file: core/codm_decoder.v
// Overview of operation
// - 01DDDSSS with no field at 110 is a register copy from SSS to DDD in 4 cycles.
// - 01110SSS stores the register chosen by SSS to memory in 7 cycles.
// - 01DDD110 loads the register chosen by DDD from memory in 7 cycles.
// - 00PP0001 loads a 16-bit immediate into pair B/C, D/E or H/L by pair code in 10 cycles.
// - 00110001 loads the immediate into the stack pointer, pair code 11 meaning the stack pointer, 10 cycles.
// - 11101011 swaps D/E with H/L in 4 cycles with no bus data.
// - 11PP0101 pushes pair B/C, D/E or H/L onto the stack in 12 cycles.
// - 11110101 pushes accumulator and flags, pair code 11 meaning that pair, 12 cycles.
// - 11PP0001 pops two stack bytes into pair B/C, D/E or H/L in 10 cycles.
// - 11110001 pops two stack bytes into accumulator and flags in 10 cycles.
// - 11100011 exchanges H/L with the two top stack bytes in 16 cycles.
// - 11111001 copies H/L into the stack pointer in 6 cycles without memory transfer.
`timescale 1ns/10ps
`default_nettype none

`include "codm_consts.vh"

module codm_decoder #(
	parameter CYC_W = `CODM_CYC_W
) (
	sys_clk,
	reset,
	opcode,
	opcode_valid,
	opcode_ready,
	dec_valid,
	dec_class,
	dst_field,
	src_field,
	dst_sel,
	src_sel,
	pair_code,
	pair_is_sp,
	pair_is_af,
	cycle_count,
	mem_read,
	mem_write,
	unsupported,
	exec_done
);
	input  wire             sys_clk;
	input  wire             reset;
	input  wire [7:0]       opcode;
	input  wire             opcode_valid;
	output wire             opcode_ready;
	output reg              dec_valid;
	output reg  [3:0]       dec_class;
	output reg  [2:0]       dst_field;
	output reg  [2:0]       src_field;
	output reg  [7:0]       dst_sel;
	output reg  [7:0]       src_sel;
	output reg  [1:0]       pair_code;
	output reg              pair_is_sp;
	output reg              pair_is_af;
	output reg  [CYC_W-1:0] cycle_count;
	output reg              mem_read;
	output reg              mem_write;
	output reg              unsupported;
	output reg              exec_done;

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'h1;
	localparam [1:0] ST_EXEC = 2'h2;

	reg  [1:0]       state_q;
	reg  [1:0]       state_d;
	reg  [CYC_W-1:0] remain_q;
	reg  [CYC_W-1:0] remain_d;

	reg  [3:0]       cls_d;
	reg  [CYC_W-1:0] cyc_d;
	reg              mem_rd_d;
	reg              mem_wr_d;
	reg              is_sp_d;
	reg              is_af_d;
	reg              unsup_d;

	wire [7:0]       dst_sel_w;
	wire [7:0]       src_sel_w;
	wire             dst_mem;
	wire             src_mem;
	wire             accept;
	wire             special_pair;

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	codm_field_map #(
		.NREG   (8)
	) u_dst_map (
		.code   (opcode[5:3]),
		.sel    (dst_sel_w),
		.is_mem (dst_mem)
	);

	codm_field_map #(
		.NREG   (8)
	) u_src_map (
		.code   (opcode[2:0]),
		.sel    (src_sel_w),
		.is_mem (src_mem)
	);

	assign special_pair = (opcode[5:4] == `CODM_PAIR_SPECIAL);
	assign opcode_ready = state_q[0];
	assign accept       = opcode_valid && opcode_ready;

	// ----------------------------------------
	// Opcode classification
	// ----------------------------------------
	always @* begin
		cls_d    = `CODM_CLS_NONE;
		cyc_d    = `CODM_CYC_NONE;
		mem_rd_d = 1'b0;
		mem_wr_d = 1'b0;
		is_sp_d  = 1'b0;
		is_af_d  = 1'b0;
		unsup_d  = 1'b0;
		if (opcode[7:6] == `CODM_GRP_MOVE) begin
			if (dst_mem && src_mem) begin
				unsup_d = 1'b1;
			end else if (dst_mem) begin
				cls_d    = `CODM_CLS_STORE_MEM;
				cyc_d    = `CODM_CYC_MEM_MOVE;
				mem_wr_d = 1'b1;
			end else if (src_mem) begin
				cls_d    = `CODM_CLS_LOAD_MEM;
				cyc_d    = `CODM_CYC_MEM_MOVE;
				mem_rd_d = 1'b1;
			end else begin
				cls_d = `CODM_CLS_COPY_REG;
				cyc_d = `CODM_CYC_COPY;
			end
		end else if (opcode[7:6] == `CODM_GRP_LOW && opcode[3:0] == `CODM_NIB_PAIR_LOAD) begin
			cls_d    = `CODM_CLS_LOAD_PAIR;
			cyc_d    = `CODM_CYC_LOAD_PAIR;
			mem_rd_d = 1'b1;
			is_sp_d  = special_pair;
		end else if (opcode == `CODM_OP_SWAP_DE_HL) begin
			cls_d = `CODM_CLS_SWAP_DE_HL;
			cyc_d = `CODM_CYC_SWAP_DE_HL;
		end else if (opcode[7:6] == `CODM_GRP_HIGH && opcode[3:0] == `CODM_NIB_PUSH) begin
			cls_d    = `CODM_CLS_PUSH;
			cyc_d    = `CODM_CYC_PUSH;
			mem_wr_d = 1'b1;
			is_af_d  = special_pair;
		end else if (opcode[7:6] == `CODM_GRP_HIGH && opcode[3:0] == `CODM_NIB_POP) begin
			cls_d    = `CODM_CLS_POP;
			cyc_d    = `CODM_CYC_POP;
			mem_rd_d = 1'b1;
			is_af_d  = special_pair;
		end else if (opcode == `CODM_OP_SWAP_TOP_HL) begin
			cls_d    = `CODM_CLS_SWAP_TOP;
			cyc_d    = `CODM_CYC_SWAP_TOP;
			mem_rd_d = 1'b1;
			mem_wr_d = 1'b1;
		end else if (opcode == `CODM_OP_HL_TO_SP) begin
			cls_d = `CODM_CLS_HL_TO_SP;
			cyc_d = `CODM_CYC_HL_TO_SP;
		end else begin
			unsup_d = 1'b1;
		end
	end

	// ----------------------------------------
	// Occupancy sequencing
	// ----------------------------------------
	always @* begin
		state_d  = state_q;
		remain_d = remain_q;
		case (state_q)
			ST_IDLE: begin
				if (accept && cyc_d > `CODM_CYC_ONE) begin
					state_d  = ST_EXEC;
					remain_d = cyc_d - `CODM_CYC_ONE;
				end
			end
			ST_EXEC: begin
				remain_d = remain_q - `CODM_CYC_ONE;
				if (remain_q == `CODM_CYC_ONE) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d  = ST_IDLE;
				remain_d = `CODM_CYC_NONE;
			end
		endcase
	end

	// ----------------------------------------
	// Registered decode outputs
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			state_q     <= ST_IDLE;
			remain_q    <= `CODM_CYC_NONE;
			dec_valid   <= 1'b0;
			dec_class   <= `CODM_CLS_NONE;
			dst_field   <= 3'h0;
			src_field   <= 3'h0;
			dst_sel     <= 8'h00;
			src_sel     <= 8'h00;
			pair_code   <= 2'h0;
			pair_is_sp  <= 1'b0;
			pair_is_af  <= 1'b0;
			cycle_count <= `CODM_CYC_NONE;
			mem_read    <= 1'b0;
			mem_write   <= 1'b0;
			unsupported <= 1'b0;
			exec_done   <= 1'b0;
		end else begin
			state_q   <= state_d;
			remain_q  <= remain_d;
			dec_valid <= accept;
			exec_done <= (state_q == ST_EXEC) && (remain_q == `CODM_CYC_ONE);
			if (accept) begin
				dec_class   <= cls_d;
				dst_field   <= opcode[5:3];
				src_field   <= opcode[2:0];
				dst_sel     <= dst_sel_w;
				src_sel     <= src_sel_w;
				pair_code   <= opcode[5:4];
				pair_is_sp  <= is_sp_d;
				pair_is_af  <= is_af_d;
				cycle_count <= cyc_d;
				mem_read    <= mem_rd_d;
				mem_write   <= mem_wr_d;
				unsupported <= unsup_d;
			end
		end
	end

endmodule

`default_nettype wire

// file: core/codm_field_map.v
`timescale 1ns/10ps
`default_nettype none

`include "codm_consts.vh"

module codm_field_map #(
	parameter NREG = 8
) (
	code,
	sel,
	is_mem
);
	input  wire [2:0]      code;
	output wire [NREG-1:0] sel;
	output wire            is_mem;

	// ----------------------------------------
	// One-hot register select, memory code masked out
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NREG; i = i + 1) begin : g_sel
			localparam [31:0] IDX_FULL = i;
			localparam [2:0]  IDX      = IDX_FULL[2:0];
			assign sel[i] = (code == IDX) && (IDX != `CODM_MEM_CODE);
		end
	endgenerate

	assign is_mem = (code == `CODM_MEM_CODE);

endmodule

`default_nettype wire

// file: dv/codm_chk.sv
`timescale 1ns/10ps
`default_nettype none
module codm_chk #(
	parameter CYC_W = 5
) (
	input wire logic             sys_clk,
	input wire logic             reset,
	input wire logic [7:0]       opcode,
	input wire logic             opcode_valid,
	input wire logic             opcode_ready,
	input wire logic             dec_valid,
	input wire logic [3:0]       dec_class,
	input wire logic [7:0]       dst_sel,
	input wire logic [7:0]       src_sel,
	input wire logic [1:0]       pair_code,
	input wire logic             pair_is_sp,
	input wire logic             pair_is_af,
	input wire logic             mem_read,
	input wire logic             mem_write,
	input wire logic [CYC_W-1:0] cycle_count
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire acc = opcode_valid && opcode_ready;
	wire [1:0] grp = opcode[7:6];
	wire d_m = opcode[5:3] == 3'h6;
	wire s_m = opcode[2:0] == 3'h6;
	a_copy_decode: assert property (acc && grp == 2'h1 && !d_m && !s_m |=>
		dec_class == 4'h1 && cycle_count == 4) else $error("bad copy");
	a_store_decode: assert property (acc && opcode[7:3] == 5'h0e && !s_m |=>
		dec_class == 4'h2 && cycle_count == 7 && mem_write) else $error("bad store");
	a_load_decode: assert property (acc && grp == 2'h1 && !d_m && s_m |=>
		dec_class == 4'h3 && cycle_count == 7 && mem_read) else $error("bad load");
	a_pair_load: assert property (acc && grp == 2'h0 && opcode[3:0] == 4'h1 |=>
		dec_class == 4'h4 && cycle_count == 10 && pair_is_sp == (pair_code == 2'h3)) else $error("bad pair");
	a_push_decode: assert property (acc && grp == 2'h3 && opcode[3:0] == 4'h5 |=>
		dec_class == 4'h6 && cycle_count == 12 && pair_is_af == (pair_code == 2'h3)) else $error("bad push");
	a_swap_regs: assert property (acc && opcode == 8'heb |=>
		dec_class == 4'h5 && cycle_count == 4 && !mem_read && !mem_write) else $error("bad swap");
	a_hl_to_sp: assert property (acc && opcode == 8'hf9 |=>
		dec_class == 4'h9 && cycle_count == 6 && !mem_read && !mem_write) else $error("bad sp copy");
	a_mem_code: assert property (dec_valid |-> !dst_sel[6] && !src_sel[6])
		else $error("memory code selected");
	a_pop_decode: assert property (acc && grp == 2'h3 && opcode[3:0] == 4'h1 |=>
		dec_class == 4'h7 && cycle_count == 10 && mem_read && pair_is_af == (pair_code == 2'h3)) else $error("bad pop");
	a_swap_top: assert property (acc && opcode == 8'he3 |=>
		dec_class == 4'h8 && cycle_count == 16 && mem_read && mem_write) else $error("bad stack swap");
	a_decode_valid: assert property (acc |=> dec_valid)
		else $error("decode not presented");
	cover property (acc && opcode == 8'hf5);
	cover property (acc && opcode == 8'he3);
	cover property (dec_valid && dec_class == 4'h0);
endmodule
bind codm_decoder codm_chk #(.CYC_W(CYC_W)) i_codm_chk (.opcode, .sys_clk, .reset, .opcode_valid,
	.opcode_ready, .dec_valid, .dec_class, .dst_sel, .src_sel, .pair_code, .pair_is_sp, .pair_is_af,
	.mem_read, .mem_write, .cycle_count);
`default_nettype wire

// file: dv/codm_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "codm_consts.vh"
module codm_decoder_tb;
	logic      sys_clk = 1'b0;
	logic      reset   = 1'b1;
	int        fails, n_compared;
	bit        ok;
	wire [7:0] opcode, dst_sel, src_sel;
	wire [3:0] dec_class;
	wire [2:0] dst_field, src_field;
	wire [1:0] pair_code;
	wire [4:0] cycle_count;
	wire       opcode_valid, opcode_ready, dec_valid, pair_is_sp, pair_is_af;
	wire       mem_read, mem_write, unsupported, exec_done;
	always #2.5 sys_clk = ~sys_clk;
	codm_decoder i_codm_decoder (.sys_clk, .reset, .opcode, .opcode_valid, .opcode_ready, .dec_valid,
		.dec_class, .dst_field, .src_field, .dst_sel, .src_sel, .pair_code, .pair_is_sp, .pair_is_af,
		.cycle_count, .mem_read, .mem_write, .unsupported, .exec_done);
	codm_prog_mem i_codm_prog_mem (.sys_clk, .opcode_ready, .opcode, .opcode_valid);
	task automatic conclude;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Offers one opcode, checks the decode, then waits out the occupancy
	task automatic dec(input logic [7:0] op, input logic [3:0] cls, input logic [4:0] cyc, input logic [1:0] mem);
		int n;
		@(posedge sys_clk);
		i_codm_prog_mem.send(op, 1'b0, ok);
		if (!ok) begin
			fails++;
			conclude;
		end
		@(negedge sys_clk);
		chk(dec_valid, 1'b1);
		chk(dec_class, cls);
		chk(cycle_count, cyc);
		chk({mem_read, mem_write}, mem);
		chk({dst_field, src_field}, op[5:0]);
		chk(unsupported, cls == 4'h0);
		chk(opcode_ready, cyc < 5'h02);
		n = 1;
		while (cyc > 5'h01 && exec_done !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 40) begin
			fails++;
			conclude;
		end
		if (cyc > 5'h01) begin
			// Done pulse shows in the first free cycle after the busy ones
			chk(n, cyc);
			chk(opcode_ready, 1'b1);
		end
	endtask
	task automatic t_copy;
		for (int d = 0; d < 8; d++) for (int s = 0; s < 8; s++) if (d != 6 && s != 6) begin
			dec({2'h1, d[2:0], s[2:0]}, `CODM_CLS_COPY_REG, 5'h04, 2'h0);
			chk(dst_sel, 8'h01 << d);
			chk(src_sel, 8'h01 << s);
		end
		$display("t_copy done");
	endtask
	task automatic t_mem;
		for (int r = 0; r < 8; r++) if (r != 6) begin
			dec({5'h0e, r[2:0]}, `CODM_CLS_STORE_MEM, 5'h07, 2'h1);
			chk(dst_sel, 8'h00);
			dec({2'h1, r[2:0], 3'h6}, `CODM_CLS_LOAD_MEM, 5'h07, 2'h2);
			chk(src_sel, 8'h00);
		end
		$display("t_mem done");
	endtask
	task automatic t_pairs;
		for (int p = 0; p < 4; p++) begin
			dec({2'h0, p[1:0], 4'h1}, `CODM_CLS_LOAD_PAIR, 5'h0a, 2'h2);
			chk({pair_code, pair_is_sp, pair_is_af}, {p[1:0], p == 3, 1'b0});
			dec({2'h3, p[1:0], 4'h5}, `CODM_CLS_PUSH, 5'h0c, 2'h1);
			chk({pair_code, pair_is_sp, pair_is_af}, {p[1:0], 1'b0, p == 3});
			dec({2'h3, p[1:0], 4'h1}, `CODM_CLS_POP, 5'h0a, 2'h2);
			chk({pair_code, pair_is_sp, pair_is_af}, {p[1:0], 1'b0, p == 3});
		end
		$display("t_pairs done");
	endtask
	task automatic t_swaps;
		dec(8'heb, `CODM_CLS_SWAP_DE_HL, 5'h04, 2'h0);
		dec(8'he3, `CODM_CLS_SWAP_TOP, 5'h10, 2'h3);
		dec(8'hf9, `CODM_CLS_HL_TO_SP, 5'h06, 2'h0);
		$display("t_swaps done");
	endtask
	// Opcodes outside the set keep the decoder free for a back-to-back byte
	task automatic t_unsup;
		dec(8'h76, `CODM_CLS_NONE, 5'h00, 2'h0);
		@(posedge sys_clk);
		i_codm_prog_mem.send(8'h3a, 1'b1, ok);
		i_codm_prog_mem.send(8'h06, 1'b0, ok);
		@(negedge sys_clk);
		chk({ok, dec_valid, unsupported, dec_class}, 7'h70);
		chk({dst_field, src_field, cycle_count}, 11'h0c0);
		$display("t_unsup done");
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		t_copy;
		t_mem;
		t_pairs;
		t_swaps;
		t_unsup;
		conclude;
	end
endmodule
`default_nettype wire

// file: dv/codm_prog_mem.sv
`timescale 1ns/10ps
`default_nettype none
module codm_prog_mem (
	input  wire logic       sys_clk,
	input  wire logic       opcode_ready,
	output var  logic [7:0] opcode,
	output var  logic       opcode_valid
);
	initial opcode = 8'h00;
	initial opcode_valid = 1'b0;
	// Call at a rising edge; returns in the time step of the accepting edge
	task automatic send(input logic [7:0] b, input bit keep, output bit ok);
		int n;
		n = 0;
		opcode <= b;
		opcode_valid <= 1'b1;
		do begin
			@(negedge sys_clk);
			n++;
		end while (opcode_ready !== 1'b1 && n < 40);
		ok = opcode_ready === 1'b1;
		@(posedge sys_clk);
		if (!keep) begin
			opcode <= ~b;
			opcode_valid <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire
